//--- pkg/psr_pkg.sv
// Constants and state types for the parallel-load shift register
package psr_pkg;

    // Register chain geometry
    localparam int unsigned NUM_STAGES = 8;
    localparam int unsigned EDGE_CNT_W = 16;

    // Bit layout of the synchronised pin bundle
    localparam int unsigned PIN_CLK = 0;
    localparam int unsigned PIN_HOLD = 1;
    localparam int unsigned PIN_ZERO = 2;
    localparam int unsigned PIN_SEL = 3;
    localparam int unsigned PIN_SER = 4;
    localparam int unsigned PIN_PAR = 5;
    localparam int unsigned PIN_W = PIN_PAR + NUM_STAGES;

    // Pin reset levels: clock and hold high so release makes no edge
    localparam logic [PIN_W-1:0] PIN_RST = 13'h0003;

    // Register bus geometry and map
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h000;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h004;
    localparam logic [ADDR_W-1:0] ADDR_EDGES = 12'h008;

    // Control register fields
    localparam int unsigned CTRL_SOFT_ZERO = 0;
    localparam int unsigned CTRL_FREEZE = 1;

    // Status register fields
    localparam int unsigned STAT_LAST = 0;
    localparam int unsigned STAT_ZEROING = 1;
    localparam int unsigned STAT_FREEZE = 2;

    // Bus response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Synchroniser state
    typedef struct packed {
        logic [PIN_W-1:0] s1;
        logic [PIN_W-1:0] s2;
        logic [PIN_W-1:0] s3;
        logic [PIN_W-1:0] lvl;
    } psr_sync_t;

    // Core state: shift chain, gating history, control and bus slave
    typedef struct packed {
        logic [NUM_STAGES-1:0] stages;
        logic gated_prev;
        logic freeze;
        logic [EDGE_CNT_W-1:0] edge_cnt;
        logic aw_rdy;
        logic w_rdy;
        logic aw_got;
        logic w_got;
        logic [ADDR_W-1:0] awaddr;
        logic [DATA_W-1:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic ar_rdy;
        logic rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0] rresp;
    } psr_core_t;

    localparam psr_sync_t SYNC_RST = '{
        s1: PIN_RST, s2: PIN_RST, s3: PIN_RST, lvl: PIN_RST};

    localparam psr_core_t CORE_RST = '{
        gated_prev: 1'b1, aw_rdy: 1'b1, w_rdy: 1'b1, ar_rdy: 1'b1,
        default: '0};

endpackage : psr_pkg

//--- pkg/psr_pin_if.sv
// Bundle of filtered pin levels passed from the synchroniser to the core
interface psr_pin_if;
    import psr_pkg::*;

    logic [PIN_W-1:0] lvl;

    modport src (output lvl);
    modport dst (input lvl);
endinterface : psr_pin_if

//--- logic/psr_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
module psr_pin_sync
    import psr_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [PIN_W-1:0] pins_raw,
    psr_pin_if.src pins
);

    psr_sync_t q;
    psr_sync_t d;
    logic [PIN_W-1:0] agree_lvl;

    // Per pin: take the new level only once stages two and three agree
    for (genvar i = 0; i < PIN_W; i++) begin : g_agree
        assign agree_lvl[i] = (q.s2[i] == q.s3[i]) ? q.s3[i] : q.lvl[i];
    end

    // Next state of the chain
    always_comb begin
        d = q;
        d.s1 = pins_raw;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.lvl = agree_lvl;
    end

    // State register, frozen while ce is low
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= SYNC_RST;
        end else if (ce) begin
            q <= d;
        end
    end

    assign pins.lvl = q.lvl;

endmodule : psr_pin_sync

//--- logic/psr_shift_top.sv
// Eight-stage parallel-load shift register with register access
// What this block does
// - shift/load select high shifts the chain one place per effective edge.
// - select low loads the eight parallel inputs on the next effective edge.
// - during a parallel load the serial input reaches no stage.
// - clock and hold combine through a NOR; updates on clock rising.
// - clock or hold held high keeps every stage unchanged.
// - either gating input held low lets the other act as clock.
// - clear low zeroes all stages, overriding every other input.
// - shift puts serial input in stage one, each stage moves one on.
module psr_shift_top
    import psr_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Pins from the driving logic
    input wire logic clk_pin,
    input wire logic clock_gate_hold,
    input wire logic async_zero_n,
    input wire logic shift_or_load_select,
    input wire logic serial_in,
    input wire logic [NUM_STAGES-1:0] par_data,
    output logic serial_out_last_stage,
    // AXI4-Lite slave
    input wire logic [ADDR_W-1:0] s_axil_awaddr,
    input wire logic [2:0] s_axil_awprot,
    input wire logic s_axil_awvalid,
    output logic s_axil_awready,
    input wire logic [DATA_W-1:0] s_axil_wdata,
    input wire logic [3:0] s_axil_wstrb,
    input wire logic s_axil_wvalid,
    output logic s_axil_wready,
    output logic [1:0] s_axil_bresp,
    output logic s_axil_bvalid,
    input wire logic s_axil_bready,
    input wire logic [ADDR_W-1:0] s_axil_araddr,
    input wire logic [2:0] s_axil_arprot,
    input wire logic s_axil_arvalid,
    output logic s_axil_arready,
    output logic [DATA_W-1:0] s_axil_rdata,
    output logic [1:0] s_axil_rresp,
    output logic s_axil_rvalid,
    input wire logic s_axil_rready
);

    psr_pin_if pins ();
    psr_core_t q;
    psr_core_t d;
    logic [PIN_W-1:0] pins_raw;

    // Gather the pins into one bundle for the synchroniser
    always_comb begin
        pins_raw = '0;
        pins_raw[PIN_CLK] = clk_pin;
        pins_raw[PIN_HOLD] = clock_gate_hold;
        pins_raw[PIN_ZERO] = async_zero_n;
        pins_raw[PIN_SEL] = shift_or_load_select;
        pins_raw[PIN_SER] = serial_in;
        pins_raw[PIN_PAR +: NUM_STAGES] = par_data;
    end

    // All pins arrive from outside the clock domain
    psr_pin_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .pins_raw(pins_raw),
        .pins(pins)
    );

    // Filtered pin levels and derived gating terms
    logic gated_now;
    logic eff_edge;
    logic zero_pin;
    logic sel_shift;
    logic ser_lvl;
    logic [NUM_STAGES-1:0] par_lvl;

    // The NOR output falls exactly when the OR of both inputs rises
    assign gated_now = pins.lvl[PIN_CLK] | pins.lvl[PIN_HOLD];
    // Rising edge of either input while the other is low
    assign eff_edge = gated_now & ~q.gated_prev;
    assign zero_pin = ~pins.lvl[PIN_ZERO];
    assign sel_shift = pins.lvl[PIN_SEL];
    assign ser_lvl = pins.lvl[PIN_SER];
    assign par_lvl = pins.lvl[PIN_PAR +: NUM_STAGES];

    // Read data for a given address
    function automatic logic [DATA_W-1:0] read_word(
        input logic [ADDR_W-1:0] addr,
        input psr_core_t st,
        input logic zeroing
    );
        logic [DATA_W-1:0] w;
        w = '0;
        unique case (addr)
            ADDR_CTRL: begin
                w[CTRL_FREEZE] = st.freeze;
            end
            ADDR_STATUS: begin
                w[STAT_LAST] = st.stages[NUM_STAGES-1];
                w[STAT_ZEROING] = zeroing;
                w[STAT_FREEZE] = st.freeze;
            end
            ADDR_EDGES: begin
                w[EDGE_CNT_W-1:0] = st.edge_cnt;
            end
            default: begin
                w = '0;
            end
        endcase
        return w;
    endfunction : read_word

    // Address decode
    function automatic logic addr_hit(input logic [ADDR_W-1:0] addr);
        return (addr == ADDR_CTRL) || (addr == ADDR_STATUS) ||
            (addr == ADDR_EDGES);
    endfunction : addr_hit

    logic soft_zero;
    logic wr_fire;

    // Next state: bus slave, control register and shift chain
    always_comb begin
        d = q;
        soft_zero = 1'b0;
        wr_fire = q.aw_got && q.w_got && !q.bvalid;

        // Write address and data are taken independently
        if (s_axil_awvalid && q.aw_rdy) begin
            d.aw_got = 1'b1;
            d.aw_rdy = 1'b0;
            d.awaddr = s_axil_awaddr;
        end
        if (s_axil_wvalid && q.w_rdy) begin
            d.w_got = 1'b1;
            d.w_rdy = 1'b0;
            d.wdata = s_axil_wdata;
            d.wstrb = s_axil_wstrb;
        end

        // Once both halves are held, apply the write and answer
        if (wr_fire) begin
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = addr_hit(q.awaddr) ? RESP_OKAY : RESP_SLVERR;
            if (q.awaddr == ADDR_CTRL && q.wstrb[0]) begin
                d.freeze = q.wdata[CTRL_FREEZE];
                soft_zero = q.wdata[CTRL_SOFT_ZERO];
            end
        end

        // Response taken: reopen both write channels
        if (q.bvalid && s_axil_bready) begin
            d.bvalid = 1'b0;
            d.aw_rdy = 1'b1;
            d.w_rdy = 1'b1;
        end

        // Reads answer one edge after the address is taken
        if (s_axil_arvalid && q.ar_rdy) begin
            d.ar_rdy = 1'b0;
            d.rvalid = 1'b1;
            d.rdata = read_word(s_axil_araddr, q, zero_pin);
            d.rresp = addr_hit(s_axil_araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        if (q.rvalid && s_axil_rready) begin
            d.rvalid = 1'b0;
            d.ar_rdy = 1'b1;
        end

        // Track the gating level every cycle so no edge is invented later
        d.gated_prev = gated_now;

        // Clear wins over everything, including a coincident edge
        if (zero_pin || soft_zero) begin
            d.stages = '0;
        end else if (eff_edge && !q.freeze) begin
            d.edge_cnt = q.edge_cnt + 1'b1;
            if (sel_shift) begin
                // Serial bit into stage one, every stage moves on
                d.stages = {q.stages[NUM_STAGES-2:0], ser_lvl};
            end else begin
                // Broadside load; serial input is not looked at
                d.stages = par_lvl;
            end
        end
    end

    // State register, frozen while ce is low
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= CORE_RST;
        end else if (ce) begin
            q <= d;
        end
    end

    // Outputs straight from flip-flops; only the last stage leaves
    assign serial_out_last_stage = q.stages[NUM_STAGES-1];
    assign s_axil_awready = q.aw_rdy;
    assign s_axil_wready = q.w_rdy;
    assign s_axil_bvalid = q.bvalid;
    assign s_axil_bresp = q.bresp;
    assign s_axil_arready = q.ar_rdy;
    assign s_axil_rvalid = q.rvalid;
    assign s_axil_rdata = q.rdata;
    assign s_axil_rresp = q.rresp;

endmodule : psr_shift_top

//--- tb/psr_shift_asserts.sv
// Checker for clock gating, clear and bus answers
module psr_shift_asserts
    import psr_pkg::*;
(
    input wire logic aclk, aresetn, ce, clk_pin, clock_gate_hold,
    input wire logic async_zero_n, serial_out_last_stage,
    input wire logic [ADDR_W-1:0] s_axil_awaddr,
    input wire logic s_axil_awvalid, s_axil_awready,
    input wire logic s_axil_wvalid, s_axil_wready, s_axil_bvalid,
    input wire logic [1:0] s_axil_bresp,
    input wire logic s_axil_bready, s_axil_arvalid, s_axil_arready,
    input wire logic [DATA_W-1:0] s_axil_rdata,
    input wire logic s_axil_rvalid, s_axil_rready
);
    timeunit 1ns;
    timeprecision 1ns;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Bus answers stand until taken
    a_bvalid_stands: assert property (s_axil_bvalid && !s_axil_bready
        |=> s_axil_bvalid && $stable(s_axil_bresp))
        else $error("write response dropped early");
    a_rvalid_stands: assert property (s_axil_rvalid && !s_axil_rready
        |=> s_axil_rvalid && $stable(s_axil_rdata))
        else $error("read data dropped early");
    a_read_next: assert property (ce && s_axil_arvalid && s_axil_arready
        |=> s_axil_rvalid)
        else $error("read answer late");
    a_read_busy: assert property (s_axil_rvalid |-> !s_axil_arready)
        else $error("read taken during answer");
    a_write_busy: assert property (s_axil_bvalid
        |-> !s_axil_awready && !s_axil_wready)
        else $error("write taken during response");
    a_ctrl_okay: assert property (ce && s_axil_awvalid && s_axil_awready
        && s_axil_wvalid && s_axil_wready && s_axil_awaddr == ADDR_CTRL
        |-> ##2 s_axil_bvalid && s_axil_bresp == RESP_OKAY)
        else $error("control write not answered");
    // Clear zeroes the output, gated clock keeps it
    a_clear_zero: assert property (
        (ce && !async_zero_n) [*6] |-> !serial_out_last_stage)
        else $error("output not zero under clear");
    a_gate_hold: assert property (
        (ce && async_zero_n && (clk_pin || clock_gate_hold)) [*6]
        |=> $stable(serial_out_last_stage))
        else $error("output moved while gated");
endmodule : psr_shift_asserts

bind psr_shift_top psr_shift_asserts u_asserts (.*);

//--- tb/psr_host_model.sv
// Driving logic: sets all pins after an edge and holds them
module psr_host_model
    import psr_pkg::*;
(
    input wire logic aclk,
    output logic clk_pin = 1'b0,
    output logic clock_gate_hold = 1'b0,
    output logic async_zero_n = 1'b1,
    output logic shift_or_load_select = 1'b1,
    output logic serial_in = 1'b0,
    output logic [NUM_STAGES-1:0] par_data = 8'h00
);
    timeunit 1ns;
    timeprecision 1ns;

    // Drive every pin, then hold for n more edges
    task automatic put(input logic z, c, h, s, d, input logic [7:0] p,
        input int n);
        @(posedge aclk);
        async_zero_n <= z;
        clk_pin <= c;
        clock_gate_hold <= h;
        shift_or_load_select <= s;
        serial_in <= d;
        par_data <= p;
        repeat (n) @(posedge aclk);
    endtask : put
endmodule : psr_host_model

//--- tb/psr_shift_top_bench.sv
// Bench: pin sequences and register accesses with expected results
module psr_shift_top_bench
    import psr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic aclk, clk_pin, clock_gate_hold, async_zero_n, serial_out_last_stage;
    logic shift_or_load_select, serial_in, aresetn = 1'b0, zn = 1'b1;
    logic [NUM_STAGES-1:0] par_data, m = '0;
    logic [EDGE_CNT_W-1:0] ec = '0;
    logic ce = 1'b1;
    logic [2:0] s_axil_awprot = 3'h0, s_axil_arprot = 3'h0;
    logic [3:0] s_axil_wstrb = 4'hF;
    logic [ADDR_W-1:0] s_axil_awaddr = '0, s_axil_araddr = '0;
    logic [DATA_W-1:0] s_axil_wdata = '0, s_axil_rdata;
    logic [1:0] s_axil_bresp, s_axil_rresp;
    logic s_axil_awvalid = 1'b0, s_axil_wvalid = 1'b0, s_axil_bready = 1'b0;
    logic s_axil_arvalid = 1'b0, s_axil_rready = 1'b0, s_axil_awready;
    logic s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
    int bad_count = 0, n_tests = 0;

    psr_shift_top dut (.*);
    psr_host_model host (.*);

    // Free-running 10 MHz clock
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    task automatic chk(input string what, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s exp %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Bus write, address and data offered together
    task automatic axw(input logic [11:0] a, input logic [31:0] d,
        input logic [1:0] r);
        logic ta, tw;
        ta = 1'b0;
        tw = 1'b0;
        @(posedge aclk);
        s_axil_awaddr <= a;
        s_axil_wdata <= d;
        s_axil_awvalid <= 1'b1;
        s_axil_wvalid <= 1'b1;
        s_axil_bready <= 1'b1;
        // Each channel released at the edge where its ready is seen
        while (!(ta && tw)) begin
            @(posedge aclk);
            if (!ta && s_axil_awready) begin
                ta = 1'b1;
                s_axil_awvalid <= 1'b0;
            end
            if (!tw && s_axil_wready) begin
                tw = 1'b1;
                s_axil_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!s_axil_bvalid);
        s_axil_bready <= 1'b0;
        chk("bresp", {30'h0, s_axil_bresp}, {30'h0, r});
    endtask : axw

    // Bus read with expected data and response
    task automatic axr(input logic [11:0] a, input logic [31:0] d,
        input logic [1:0] r);
        @(posedge aclk);
        s_axil_araddr <= a;
        s_axil_arvalid <= 1'b1;
        s_axil_rready <= 1'b1;
        do @(posedge aclk); while (!s_axil_arready);
        s_axil_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axil_rvalid);
        s_axil_rready <= 1'b0;
        chk("rresp", {30'h0, s_axil_rresp}, {30'h0, r});
        chk("rdata", s_axil_rdata, d);
    endtask : axr

    // One edge from clock pin or hold, then output against model
    task automatic sh(input logic s, d, input logic [7:0] p,
        input logic vh, eff);
        host.put(zn, 1'b0, 1'b0, s, d, p, 5);
        host.put(zn, !vh, vh, s, d, p, 6);
        host.put(zn, 1'b0, 1'b0, s, d, p, 2);
        if (eff) begin
            m = s ? {m[6:0], d} : p;
            ec++;
        end
        chk("last stage", {31'h0, serial_out_last_stage}, {31'h0, m[7]});
    endtask : sh

    task automatic complete_run();
        $display("mismatches %0d of %0d checks", bad_count, n_tests);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run

    // Reset, then the scenarios
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        // Let the pin synchroniser see the idle clear level
        repeat (4) @(posedge aclk);
        axr(ADDR_STATUS, 32'h0, RESP_OKAY);
        axr(ADDR_EDGES, 32'h0, RESP_OKAY);
        sh(1'b0, 1'b1, 8'hA4, 1'b0, 1'b1);
        for (int i = 0; i < 10; i++) begin
            sh(1'b1, i[1] ^ i[0], 8'h5B, 1'b0, 1'b1);
        end
        sh(1'b1, 1'b1, 8'h00, 1'b1, 1'b1);
        // Load on the clock rise, then a rise under hold must be ignored
        host.put(zn, 1'b0, 1'b0, 1'b0, 1'b0, 8'h96, 5);
        host.put(zn, 1'b1, 1'b0, 1'b0, 1'b0, 8'h96, 6);
        host.put(zn, 1'b1, 1'b1, 1'b0, 1'b0, 8'h69, 5);
        host.put(zn, 1'b0, 1'b1, 1'b0, 1'b0, 8'h69, 5);
        host.put(zn, 1'b1, 1'b1, 1'b0, 1'b0, 8'h69, 5);
        host.put(zn, 1'b0, 1'b1, 1'b0, 1'b0, 8'h69, 5);
        m = 8'h96;
        ec++;
        chk("held", {31'h0, serial_out_last_stage}, 32'h1);
        // Frozen edges leave the chain alone
        axw(ADDR_CTRL, 32'h2, RESP_OKAY);
        axr(ADDR_CTRL, 32'h2, RESP_OKAY);
        sh(1'b0, 1'b0, ~m, 1'b0, 1'b0);
        axr(ADDR_STATUS, {29'h0, 1'b1, 1'b0, m[7]}, RESP_OKAY);
        axw(ADDR_CTRL, 32'h0, RESP_OKAY);
        // Soft zero empties the chain and reads back as zero
        axw(ADDR_CTRL, 32'h1, RESP_OKAY);
        m = '0;
        chk("soft zero", {31'h0, serial_out_last_stage}, 32'h0);
        axr(ADDR_CTRL, 32'h0, RESP_OKAY);
        // Clear wins over a load edge
        sh(1'b0, 1'b0, 8'hFF, 1'b0, 1'b1);
        zn = 1'b0;
        m = '0;
        sh(1'b0, 1'b0, 8'hFF, 1'b0, 1'b0);
        axr(ADDR_STATUS, 32'h2, RESP_OKAY);
        zn = 1'b1;
        host.put(zn, 1'b0, 1'b0, 1'b0, 1'b0, 8'hFF, 5);
        axw(12'h00C, 32'h1, RESP_SLVERR);
        axr(12'h00C, 32'h0, RESP_SLVERR);
        axr(ADDR_EDGES, {16'h0, ec}, RESP_OKAY);
        complete_run();
    end

    // Hang guard, far past the expected run length
    initial begin
        repeat (6000) @(posedge aclk);
        bad_count++;
        complete_run();
    end
endmodule : psr_shift_top_bench
